// [rtl/limit_monitor.sv]
`timescale 1ns/100ps
// Summary of operation
// R1: permissive high inside safe region, else low
// R2: side select chooses high, low or both
// R3: trip latches; clear pin works only when safe
// R4: high trip clears below high minus hysteresis
// R5: low trip clears above low plus hysteresis
// R6: hysteresis 1..9999, or 2..5555 celsius
// R7: range bounds within -99999..99999
// R8: upper threshold above maximum is refused
// R9: both thresholds held within min..max bounds; code checks only newly written thresholds, not kept ones
// R10: software clear resets latch when fault gone
// R11: input error gives fail status, output off
// R12: permissive wired straight to energy driver
// R13: per-cycle evaluation; latch powers up tripped
module limit_monitor
  import limit_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic i_sys_rst, // sync reset, active high
  input wire logic signed [VAL_W-1:0] i_value, // monitored process value
  input wire logic i_value_err, // sensor reports an error
  input wire logic i_clear_pin, // digital clear input, async pin
  input wire logic i_sw_clear, // software clear, pulse = Clear
  input wire logic [1:0] i_side, // side selection code
  input wire logic i_cfg_we, // settings write strobe
  input wire logic i_celsius, // hysteresis in celsius
  input wire logic signed [VAL_W-1:0] i_min_sp, // minimum bound
  input wire logic signed [VAL_W-1:0] i_max_sp, // maximum bound
  input wire logic signed [VAL_W-1:0] i_hi_sp, // upper threshold
  input wire logic signed [VAL_W-1:0] i_lo_sp, // lower threshold
  input wire logic signed [VAL_W-1:0] i_hyst, // hysteresis
  output logic o_energy_en, // fixed drive to energy-source switch
  output logic [1:0] o_status, // safe, tripped or fail
  output logic o_hi_tripped, // high side caused the trip
  output logic o_lo_tripped, // low side caused the trip
  output logic o_cfg_err // last settings write refused a field
);
  logic clr_sync; // synchronised clear pin level
  logic clr_prev_q; // previous clear level, for edge
  logic clr_rise; // clear pin asserted this cycle
  logic signed [VAL_W-1:0] hi_sp, lo_sp, hyst; // held settings
  logic signed [VAL_W:0] hi_rel, lo_rel; // release points, one bit wider
  logic hi_en, lo_en; // enabled sides
  logic hi_cross, lo_cross; // limit crossed now
  logic hi_gone, lo_gone; // condition cleared with hysteresis
  logic fault_gone; // all latched causes cleared
  logic clr_req; // any clear request
  latch_e state_q, state_d; // latch state
  logic hi_lat_q, lo_lat_q; // which side tripped

  // clear pin comes from outside; pass it through two flops
  limit_sync u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_clear_pin),
    .o_sync(clr_sync)
  );

  limit_cfg u_cfg (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_cfg_we(i_cfg_we),
    .i_celsius(i_celsius),
    .i_min_sp(i_min_sp),
    .i_max_sp(i_max_sp),
    .i_hi_sp(i_hi_sp),
    .i_lo_sp(i_lo_sp),
    .i_hyst(i_hyst),
    .o_hi_sp(hi_sp),
    .o_lo_sp(lo_sp),
    .o_hyst(hyst),
    .o_cfg_err(o_cfg_err)
  );

  // edge detect on the synchronised level only; a held pin clears once
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      clr_prev_q <= 1'b0;
    end else begin
      clr_prev_q <= clr_sync;
    end
  end
  assign clr_rise = clr_sync && !clr_prev_q;
  assign clr_req = clr_rise || i_sw_clear; // R3 R10

  // comparisons, evaluated every cycle
  always_comb begin
    hi_en = (i_side == SIDE_BOTH) || (i_side == SIDE_HIGH); // R2
    lo_en = (i_side == SIDE_BOTH) || (i_side == SIDE_LOW); // R2
    // widened so threshold +- hysteresis cannot wrap
    // concatenations are unsigned, so each widened operand is marked signed again
    hi_rel = $signed({hi_sp[VAL_W-1], hi_sp}) - $signed({hyst[VAL_W-1], hyst});
    lo_rel = $signed({lo_sp[VAL_W-1], lo_sp}) + $signed({hyst[VAL_W-1], hyst});
    hi_cross = hi_en && (i_value > hi_sp); // R1
    lo_cross = lo_en && (i_value < lo_sp); // R1
    hi_gone = $signed({i_value[VAL_W-1], i_value}) <= hi_rel; // R4
    lo_gone = $signed({i_value[VAL_W-1], i_value}) >= lo_rel; // R5
    // an errored input never counts as cleared
    fault_gone = !i_value_err && !hi_cross && !lo_cross
      && (!hi_lat_q || hi_gone) && (!lo_lat_q || lo_gone); // R3 R4 R5
  end

  // latch transitions
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SAFE: begin
        if (i_value_err || hi_cross || lo_cross) begin
          state_d = ST_TRIP; // R1 R11
        end
      end
      ST_TRIP: begin
        if (clr_req && fault_gone) begin
          state_d = ST_SAFE; // R3 R10
        end
      end
      default: begin
        state_d = ST_TRIP; // illegal code fails safe
      end
    endcase
  end

  // latch powers up tripped so energy stays off until a clear
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_TRIP; // R13
    end else begin
      state_q <= state_d; // R13
    end
  end

  // remember the cause; a new crossing adds while tripped
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      hi_lat_q <= 1'b0;
      lo_lat_q <= 1'b0;
    end else if (state_d == ST_SAFE) begin
      hi_lat_q <= 1'b0;
      lo_lat_q <= 1'b0;
    end else begin
      hi_lat_q <= hi_lat_q || hi_cross; // R4
      lo_lat_q <= lo_lat_q || lo_cross; // R5
    end
  end

  // permissive and status come from flops; no path can disconnect them
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_energy_en <= 1'b0;
      o_status <= STAT_TRIP;
    end else begin
      o_energy_en <= (state_d == ST_SAFE); // R1 R12
      if (i_value_err) begin
        o_status <= STAT_FAIL; // R11
      end else if (state_d == ST_TRIP) begin
        o_status <= STAT_TRIP;
      end else begin
        o_status <= STAT_SAFE;
      end
    end
  end
  assign o_hi_tripped = hi_lat_q;
  assign o_lo_tripped = lo_lat_q;

  // crossing while safe drops the output next cycle
  trip_drop_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R1
    state_q == ST_SAFE && (hi_cross || lo_cross) |=> !o_energy_en)
    else $error("limit crossed but output stayed on");
  side_high_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R2
    i_side == SIDE_HIGH |-> !lo_cross)
    else $error("low side monitored in high-only mode");
  latch_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R3
    state_q == ST_TRIP && !clr_req |=> state_q == ST_TRIP)
    else $error("latch released without a clear");
  hi_release_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R4
    state_q == ST_TRIP && hi_lat_q && !hi_gone |=> state_q == ST_TRIP)
    else $error("high trip released inside hysteresis");
  lo_release_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R5
    state_q == ST_TRIP && lo_lat_q && !lo_gone |=> state_q == ST_TRIP)
    else $error("low trip released inside hysteresis");
  sw_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R10
    state_q == ST_TRIP && i_sw_clear && fault_gone |=> o_energy_en)
    else $error("software clear did not restore output");
  err_fail_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R11
    i_value_err |=> o_status == STAT_FAIL && !o_energy_en)
    else $error("input error did not force fail");
  out_state_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R12
    o_energy_en == (state_q == ST_SAFE))
    else $error("output not tied to latch state");

  trip_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    state_q == ST_SAFE ##1 state_q == ST_TRIP);
  pin_clear_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    clr_rise && state_q == ST_TRIP ##1 state_q == ST_SAFE);
  sw_clear_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    i_sw_clear && state_q == ST_TRIP ##1 state_q == ST_SAFE);
  fail_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    o_status == STAT_FAIL);
endmodule

// [include/limit_pkg.sv]
package limit_pkg;
  // signed value width: covers -99,999..99,999 with margin
  localparam int VAL_W = 18;
  localparam logic signed [VAL_W-1:0] SP_MIN_LIM = -18'sd99999;
  localparam logic signed [VAL_W-1:0] SP_MAX_LIM = 18'sd99999;
  localparam logic signed [VAL_W-1:0] HYST_MIN_FU = 18'sd1;
  localparam logic signed [VAL_W-1:0] HYST_MAX_FU = 18'sd9999;
  localparam logic signed [VAL_W-1:0] HYST_MIN_C = 18'sd2;
  localparam logic signed [VAL_W-1:0] HYST_MAX_C = 18'sd5555;
  // reset values of the held settings
  localparam logic signed [VAL_W-1:0] RST_SP_MIN = 18'sd0;
  localparam logic signed [VAL_W-1:0] RST_SP_MAX = 18'sd0;
  localparam logic signed [VAL_W-1:0] RST_SP_HI = 18'sd0;
  localparam logic signed [VAL_W-1:0] RST_SP_LO = 18'sd0;
  localparam logic signed [VAL_W-1:0] RST_HYST = 18'sd1;
  // side selection codes
  typedef enum logic [1:0] {
    SIDE_BOTH = 2'h0,
    SIDE_HIGH = 2'h1,
    SIDE_LOW = 2'h2
  } side_e;
  // latch states, one-hot
  typedef enum logic [1:0] {
    ST_SAFE = 2'b01,
    ST_TRIP = 2'b10
  } latch_e;
  // status codes
  localparam logic [1:0] STAT_SAFE = 2'h0;
  localparam logic [1:0] STAT_TRIP = 2'h1;
  localparam logic [1:0] STAT_FAIL = 2'h2;
endpackage

// [rtl/limit_sync.sv]
`timescale 1ns/100ps
// two-stage synchroniser for asynchronous pin levels
module limit_sync
  import limit_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic i_sys_rst, // sync reset, active high
  input wire logic i_async, // level from a pin
  output logic o_sync // synchronised level
);
  logic meta_q; // first stage, read only by the second
  // both stages clear on reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// [rtl/limit_cfg.sv]
`timescale 1ns/100ps
// settings store: refuses out-of-range writes, keeping old values
module limit_cfg
  import limit_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic i_sys_rst, // sync reset, active high
  input wire logic i_cfg_we, // write strobe for all settings, pulse
  input wire logic i_celsius, // hysteresis given in celsius
  input wire logic signed [VAL_W-1:0] i_min_sp, // new minimum bound
  input wire logic signed [VAL_W-1:0] i_max_sp, // new maximum bound
  input wire logic signed [VAL_W-1:0] i_hi_sp, // new upper threshold
  input wire logic signed [VAL_W-1:0] i_lo_sp, // new lower threshold
  input wire logic signed [VAL_W-1:0] i_hyst, // new hysteresis
  output logic signed [VAL_W-1:0] o_hi_sp, // held upper threshold
  output logic signed [VAL_W-1:0] o_lo_sp, // held lower threshold
  output logic signed [VAL_W-1:0] o_hyst, // held hysteresis
  output logic o_cfg_err // last write had a refused field
);
  logic signed [VAL_W-1:0] min_q, max_q; // held range bounds
  logic min_ok, max_ok, hi_ok, lo_ok, hy_ok; // per-field acceptance
  logic signed [VAL_W-1:0] min_n, max_n; // bounds in effect after write

  // bounds are checked first; thresholds are checked against the new bounds
  always_comb begin
    min_ok = (i_min_sp >= SP_MIN_LIM) && (i_min_sp <= SP_MAX_LIM); // R7
    max_ok = (i_max_sp >= SP_MIN_LIM) && (i_max_sp <= SP_MAX_LIM); // R7
    min_n = min_ok ? i_min_sp : min_q;
    max_n = max_ok ? i_max_sp : max_q;
    // upper above maximum is refused, lower bound inclusive too
    hi_ok = (i_hi_sp <= max_n) && (i_hi_sp >= min_n); // R8 R9
    lo_ok = (i_lo_sp <= max_n) && (i_lo_sp >= min_n); // R9
    if (i_celsius) begin
      hy_ok = (i_hyst >= HYST_MIN_C) && (i_hyst <= HYST_MAX_C); // R6
    end else begin
      hy_ok = (i_hyst >= HYST_MIN_FU) && (i_hyst <= HYST_MAX_FU); // R6
    end
  end

  // refused fields keep their old value; kept thresholds are not rechecked against new bounds
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      min_q <= RST_SP_MIN;
      max_q <= RST_SP_MAX;
      o_hi_sp <= RST_SP_HI;
      o_lo_sp <= RST_SP_LO;
      o_hyst <= RST_HYST;
      o_cfg_err <= 1'b0;
    end else if (i_cfg_we) begin
      min_q <= min_n;
      max_q <= max_n;
      if (hi_ok) begin
        o_hi_sp <= i_hi_sp;
      end
      if (lo_ok) begin
        o_lo_sp <= i_lo_sp;
      end
      if (hy_ok) begin
        o_hyst <= i_hyst;
      end
      o_cfg_err <= !(min_ok && max_ok && hi_ok && lo_ok && hy_ok);
    end
  end

  // a refused upper threshold must never be taken
  hi_refuse_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R8
    i_cfg_we && !hi_ok |=> o_hi_sp == $past(o_hi_sp))
    else $error("refused upper threshold was stored");
  hyst_range_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R6
    o_hyst >= HYST_MIN_FU && o_hyst <= HYST_MAX_FU)
    else $error("hysteresis left its range");
endmodule

// [tb/sensor_model.sv]
`timescale 1ns/100ps
// process sensor and energy switch as seen from the far side
module sensor_model
  import limit_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic signed [VAL_W-1:0] i_target, // reading to present
  input wire logic i_fault, // make the probe report an error
  input wire logic i_energy_en, // energy switch command
  output logic signed [VAL_W-1:0] o_value, // presented reading
  output logic o_value_err, // presented error flag
  output logic [15:0] o_unsafe_cnt // cycles energised with a dead probe
);
  logic err_q = 1'b0; // error seen one edge ago
  logic [15:0] cnt_q = 16'h0000; // unsafe cycles counted so far
  // the probe follows the commanded reading at once, no settling
  assign o_value = i_target;
  assign o_value_err = i_fault;
  assign o_unsafe_cnt = cnt_q;
  // energy left on a cycle after a probe fault is the hazard to catch
  always @(posedge i_clk) begin
    if (err_q && o_value_err && i_energy_en) begin
      cnt_q <= cnt_q + 16'h0001;
    end
    err_q <= o_value_err;
  end
endmodule

// [tb/tb.sv]
`timescale 1ns/100ps
// self-checking bench for the limit monitor
module tb
  import limit_pkg::*;
;
  logic clk, rst, fault, clr_pin, sw_clr, we, cel, chk, en, ht, lt, ce, val_err;
  logic [1:0] side, st;
  logic signed [VAL_W-1:0] target, val, mn, mx, hi, lo, hy;
  logic [15:0] unsafe;
  logic [5:0] q[$]; // expected {energy, status, causes, cfg error}
  int miscompares = 0, n_tests = 0, seed = 32'hf732, i;
  side_e sides[2] = '{SIDE_HIGH, SIDE_LOW};
  // the refused upper threshold comes last, so the trip after it proves it was kept out
  logic signed [VAL_W-1:0] bad[5][5] = '{'{-1000, 1000, 500, -2000, 10},
    '{-1000, 100000, 500, -500, 10}, '{-1000, 1000, 500, -500, 10000},
    '{-1000, 1000, 500, -500, 1}, '{-1000, 1000, 2000, -500, 10}};

  limit_monitor dut (.i_clk(clk), .i_sys_rst(rst), .i_value(val), .i_value_err(val_err),
    .i_clear_pin(clr_pin), .i_sw_clear(sw_clr), .i_side(side), .i_cfg_we(we), .i_celsius(cel),
    .i_min_sp(mn), .i_max_sp(mx), .i_hi_sp(hi), .i_lo_sp(lo), .i_hyst(hy), .o_energy_en(en),
    .o_status(st), .o_hi_tripped(ht), .o_lo_tripped(lt), .o_cfg_err(ce));
  sensor_model probe (.i_clk(clk), .i_target(target), .i_fault(fault), .i_energy_en(en),
    .o_value(val), .o_value_err(val_err), .o_unsafe_cnt(unsafe));

  // one comparison, counted; a mismatch is reported at once
  task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict in one place, for the normal end and the watchdog alike
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // leave a note; the watcher compares it at the next falling edge
  task automatic note(input logic [5:0] e);
    q.push_back(e);
    chk <= 1'b1;
    @(negedge clk);
    chk <= 1'b0;
  endtask
  // present a reading, optionally with a one-cycle software clear
  task automatic step(input logic signed [VAL_W-1:0] v, input logic sc);
    target = v;
    sw_clr = sc;
    @(negedge clk);
    sw_clr = 1'b0;
  endtask
  // write all five settings in one strobe
  task automatic cfg(input logic signed [VAL_W-1:0] f[5], input logic c);
    {mn, mx, hi, lo, hy} = {f[0], f[1], f[2], f[3], f[4]};
    cel = c;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // sampled half a cycle after the rising edge, when the flops have settled
  always @(negedge clk) begin
    if (chk) begin
      cmp({10'h000, en, st, ht, lt, ce}, {10'h000, q.pop_front()});
    end
  end
  // a hang costs far more than the hundred or so cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    {rst, fault, clr_pin, sw_clr, we, cel, chk} = 7'b1000000;
    side = SIDE_BOTH;
    {target, mn, mx, hi, lo, hy} = '0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    note({1'b0, STAT_TRIP, 3'b000});
    cfg('{-1000, 1000, 500, -500, 10}, 1'b0);
    note({1'b0, STAT_TRIP, 3'b000});
    step(0, 1'b1);
    note({1'b1, STAT_SAFE, 3'b000});
    $display("power-up and settings done");
    step(501, 1'b0);
    note({1'b0, STAT_TRIP, 3'b100});
    step(491, 1'b1);
    note({1'b0, STAT_TRIP, 3'b100});
    target = 490;
    clr_pin = 1'b1;
    repeat (5) @(negedge clk);
    clr_pin = 1'b0;
    note({1'b1, STAT_SAFE, 3'b000});
    step(-501, 1'b0);
    note({1'b0, STAT_TRIP, 3'b010});
    step(-491, 1'b1);
    note({1'b0, STAT_TRIP, 3'b010});
    step(-490, 1'b1);
    note({1'b1, STAT_SAFE, 3'b000});
    $display("trip and clear done");
    for (i = 0; i < 2; i++) begin
      side = sides[i];
      step(i ? 600 : -600, 1'b0);
      note({1'b1, STAT_SAFE, 3'b000});
      step(i ? -600 : 600, 1'b0);
      note({1'b0, STAT_TRIP, i ? 3'b010 : 3'b100});
      step(0, 1'b1);
      note({1'b1, STAT_SAFE, 3'b000});
    end
    side = SIDE_BOTH;
    fault = 1'b1;
    step(0, 1'b1);
    note({1'b0, STAT_FAIL, 3'b000});
    fault = 1'b0;
    step(0, 1'b0);
    note({1'b0, STAT_TRIP, 3'b000});
    step(0, 1'b1);
    note({1'b1, STAT_SAFE, 3'b000});
    $display("sides and sensor error done");
    for (i = 0; i < 5; i++) begin
      cfg(bad[i], i == 3);
      note({1'b1, STAT_SAFE, 3'b001});
    end
    // the refusal flag stands until the next write
    step(501, 1'b0);
    note({1'b0, STAT_TRIP, 3'b101});
    step(490, 1'b1);
    note({1'b1, STAT_SAFE, 3'b001});
    $display("refused settings done");
    // random readings well inside the safe band never trip
    for (i = 0; i < 20; i++) begin
      step($random(seed) % 491, 1'b0);
      note({1'b1, STAT_SAFE, 3'b001});
    end
    // let the watcher take the last note before the verdict
    @(negedge clk);
    cmp(16'(q.size()), 16'h0000);
    cmp(unsafe, 16'h0000);
    $display("random readings done");
    report_and_stop();
  end
endmodule
